/* File: hdl/sfrc_pkg.sv */
// constants, opcodes and types for the serial flash register command block
package sfrc_pkg;

  typedef enum logic [1:0]
  {
    PROTO_EXT  = 2'b00,
    PROTO_DUAL = 2'b01,
    PROTO_QUAD = 2'b10
  } sfrc_proto_type;

  typedef enum logic [4:0]
  {
    CMD_NONE       = 5'h00,
    CMD_WREN       = 5'h01,
    CMD_WRDI       = 5'h02,
    CMD_RD_SR      = 5'h03,
    CMD_RD_FSR     = 5'h04,
    CMD_RD_NVCR    = 5'h05,
    CMD_RD_VCR     = 5'h06,
    CMD_RD_EVCR    = 5'h07,
    CMD_WR_SR      = 5'h08,
    CMD_WR_NVCR    = 5'h09,
    CMD_WR_VCR     = 5'h0a,
    CMD_WR_EVCR    = 5'h0b,
    CMD_PROG       = 5'h0c,
    CMD_ERASE_ADDR = 5'h0d,
    CMD_BULK       = 5'h0e,
    CMD_SUSPEND    = 5'h0f,
    CMD_FAST_READ  = 5'h10
  } sfrc_cmd_type;

  // opcodes
  localparam logic [7:0] OP_WREN      = 8'h06;
  localparam logic [7:0] OP_WRDI      = 8'h04;
  localparam logic [7:0] OP_RD_SR     = 8'h05;
  localparam logic [7:0] OP_RD_FSR    = 8'h70;
  localparam logic [7:0] OP_RD_NVCR   = 8'hb5;
  localparam logic [7:0] OP_RD_VCR    = 8'h85;
  localparam logic [7:0] OP_RD_EVCR   = 8'h65;
  localparam logic [7:0] OP_WR_SR     = 8'h01;
  localparam logic [7:0] OP_WR_NVCR   = 8'hb1;
  localparam logic [7:0] OP_WR_VCR    = 8'h81;
  localparam logic [7:0] OP_WR_EVCR   = 8'h61;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_DUAL_PROG = 8'ha2;
  localparam logic [7:0] OP_XDUAL_ALT = 8'hd2;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_XQUAD_ALT = 8'h12;
  localparam logic [7:0] OP_OTP_PROG  = 8'h42;
  localparam logic [7:0] OP_SUB_ERASE = 8'h20;
  localparam logic [7:0] OP_SEC_ERASE = 8'hd8;
  localparam logic [7:0] OP_BULK      = 8'hc7;
  localparam logic [7:0] OP_RESUME    = 8'h7a;
  localparam logic [7:0] OP_SUSPEND   = 8'h75;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_OTP_READ  = 8'h4b;

  // frame geometry, in bits and clocks
  localparam logic [13:0] OP_BITS        = 14'd8;
  localparam logic [13:0] ADDR_BITS      = 14'd24;
  localparam logic [13:0] BYTE_BITS      = 14'd8;
  localparam logic [13:0] NVCR_BITS      = 14'd16;
  localparam logic [3:0]  DUMMY_DEFAULT  = 4'd8;
  localparam logic [3:0]  DUMMY_QUAD     = 4'd10;
  localparam logic [7:0]  ERASED_BYTE    = 8'hff;

  // field positions
  localparam int SR_WIP_BIT  = 0;
  localparam int SR_WEL_BIT  = 1;
  localparam int FSR_RDY_BIT = 7;

  // reset values
  localparam logic [5:0]  SR_PROT_RESET = 6'h00;
  localparam logic [15:0] NVCR_RESET    = 16'hffff;
  localparam logic [7:0]  VCR_RESET     = 8'hfb;
  localparam logic [7:0]  EVCR_RESET    = 8'hdf;

  // self-timed operation lengths
  localparam int CLK_MHZ               = 20;
  localparam int STATUS_WRITE_TIME_US  = 1000;
  localparam int NV_CONFIG_WRITE_US    = 2000;
  localparam int PROGRAM_TIME_US       = 500;
  localparam int ERASE_TIME_US         = 5000;
  localparam int BULK_ERASE_TIME_US    = 20000;
  localparam int STATUS_WRITE_CYCLES   = STATUS_WRITE_TIME_US * CLK_MHZ;
  localparam int NV_CONFIG_CYCLES      = NV_CONFIG_WRITE_US * CLK_MHZ;
  localparam int PROGRAM_CYCLES        = PROGRAM_TIME_US * CLK_MHZ;
  localparam int ERASE_CYCLES          = ERASE_TIME_US * CLK_MHZ;
  localparam int BULK_ERASE_CYCLES     = BULK_ERASE_TIME_US * CLK_MHZ;

endpackage : sfrc_pkg

/* File: hdl/sfrc_sync.sv */
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module sfrc_sync
  import sfrc_pkg::*;
#(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  // signals
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
        begin
          stage1[g]   <= RESET_VALUE[g];
          stage2[g]   <= RESET_VALUE[g];
          stage3[g]   <= RESET_VALUE[g];
          sync_out[g] <= RESET_VALUE[g];
        end
        else
        begin
          stage1[g] <= async_in[g];
          stage2[g] <= stage1[g];
          stage3[g] <= stage2[g];
          // one-cycle glitch between stages two and three is not taken
          if (stage2[g] == stage3[g])
            sync_out[g] <= stage3[g];
        end
      end
    end
  endgenerate

endmodule : sfrc_sync

/* File: hdl/sfrc_top.sv */
// register command interpreter: serial link front end and self-timed register core
`timescale 1ns/1ps
module sfrc_top
  import sfrc_pkg::*;
#(
  parameter int STATUS_WRITE_CNT = STATUS_WRITE_CYCLES,
  parameter int NV_CONFIG_CNT    = NV_CONFIG_CYCLES,
  parameter int PROGRAM_CNT      = PROGRAM_CYCLES,
  parameter int ERASE_CNT        = ERASE_CYCLES,
  parameter int BULK_ERASE_CNT   = BULK_ERASE_CYCLES
)
(
  // core clock and reset
  input  wire logic       CLK_IN,
  input  wire logic       ARST_N_IN,
  // serial link
  input  wire logic       SCK_IN,
  input  wire logic       CS_N_IN,
  input  wire logic [3:0] DQ_IN,
  output logic      [3:0] DQ_OUT,
  output logic      [3:0] DQ_OE_OUT,
  // configuration
  input  wire logic [1:0] PROTOCOL_IN,
  input  wire logic [3:0] DUMMY_CFG_IN,
  // register state
  output logic      [7:0] STATUS_OUT,
  output logic      [7:0] FLAG_STATUS_OUT,
  output logic      [15:0] NVCR_OUT,
  output logic      [7:0] VCR_OUT,
  output logic      [7:0] EVCR_OUT
);

  localparam int SYNC_W = 8;

  // opcode decode, filtered by the protocol now active
  function automatic sfrc_cmd_type decode(input logic [7:0] op, input logic [1:0] proto);
    sfrc_cmd_type c;
    c = CMD_NONE;
    case (op)
      OP_WREN:      c = CMD_WREN;
      OP_WRDI:      c = CMD_WRDI;
      OP_RD_SR:     c = CMD_RD_SR;
      OP_RD_FSR:    c = CMD_RD_FSR;
      OP_RD_NVCR:   c = CMD_RD_NVCR;
      OP_RD_VCR:    c = CMD_RD_VCR;
      OP_RD_EVCR:   c = CMD_RD_EVCR;
      OP_WR_SR:     c = CMD_WR_SR;
      OP_WR_NVCR:   c = CMD_WR_NVCR;
      OP_WR_VCR:    c = CMD_WR_VCR;
      OP_WR_EVCR:   c = CMD_WR_EVCR;
      OP_PAGE_PROG: c = CMD_PROG;
      OP_OTP_PROG:  c = CMD_PROG;
      OP_DUAL_PROG: c = (proto == PROTO_QUAD) ? CMD_NONE : CMD_PROG;
      OP_XDUAL_ALT: c = (proto == PROTO_QUAD) ? CMD_NONE : CMD_PROG;
      OP_QUAD_PROG: c = (proto == PROTO_DUAL) ? CMD_NONE : CMD_PROG;
      OP_XQUAD_ALT: c = (proto == PROTO_DUAL) ? CMD_NONE : CMD_PROG;
      OP_SUB_ERASE: c = CMD_ERASE_ADDR;
      OP_SEC_ERASE: c = CMD_ERASE_ADDR;
      OP_BULK:      c = CMD_BULK;
      OP_SUSPEND:   c = CMD_SUSPEND;
      OP_RESUME:    c = CMD_SUSPEND;
      OP_FAST_READ: c = CMD_FAST_READ;
      OP_OTP_READ:  c = CMD_FAST_READ;
      default:      c = CMD_NONE;
    endcase
    return c;
  endfunction : decode

  // lanes per clock as a shift: extended 0, dual 1, quad 2
  function automatic logic [1:0] lane_shift(input logic [1:0] proto);
    logic [1:0] s;
    s = 2'd0;
    case (proto)
      PROTO_DUAL: s = 2'd1;
      PROTO_QUAD: s = 2'd2;
      default:    s = 2'd0;
    endcase
    return s;
  endfunction : lane_shift

  // core-side shadows, frozen while a frame is open, read by the link logic
  logic [7:0]   shadow_status;
  logic [7:0]   shadow_flag;
  logic [15:0]  shadow_nvcr;
  logic [7:0]   shadow_vcr;
  logic [7:0]   shadow_evcr;
  logic [1:0]   shadow_proto;
  logic [3:0]   shadow_dummy;

  // link-side capture; frame_tog, frame_clks, opcode and rx_shift are held after chip select rises for the core to read
  logic         in_frame;
  logic         frame_tog;
  logic [13:0]  frame_clks;
  logic [7:0]   opcode;
  logic [15:0]  rx_shift;
  logic [3:0]   out_pos;
  logic         nv_done;

  // ---------------- link domain ----------------
  // chip select high closes the frame at once, whether or not the clock still runs
  wire          link_rst_n  = ARST_N_IN & ~CS_N_IN;
  wire [1:0]    lshift      = lane_shift(shadow_proto);
  wire [13:0]   op_clks     = OP_BITS >> lshift;
  wire [13:0]   addr_clks   = ADDR_BITS >> lshift;
  wire [3:0]    dummy_clks  = (shadow_dummy != '0) ? shadow_dummy :
                              ((shadow_proto == PROTO_QUAD) ? DUMMY_QUAD : DUMMY_DEFAULT);
  wire [13:0]   clk_idx     = in_frame ? frame_clks : '0;
  wire [3:0]    rx_bits     = (shadow_proto == PROTO_QUAD) ? DQ_IN :
                              (shadow_proto == PROTO_DUAL) ? {2'b00, DQ_IN[1:0]} :
                              {3'b000, DQ_IN[0]};
  wire [15:0]   rx_base     = in_frame ? rx_shift : '0;
  // shift by the lane count (1, 2 or 4), not by its log
  wire [2:0]    lanes       = 3'd1 << lshift;
  wire [15:0]   next_rx     = (rx_base << lanes) | {12'h000, rx_bits};
  wire [13:0]   next_clks   = (frame_clks == '1) ? frame_clks : frame_clks + 14'd1;

  always_ff @(posedge SCK_IN or negedge link_rst_n)
  begin
    if (!link_rst_n)
      in_frame <= 1'b0;
    else
      in_frame <= 1'b1;
  end

  always_ff @(posedge SCK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      frame_tog  <= 1'b0;
      frame_clks <= '0;
      opcode     <= '0;
      rx_shift   <= '0;
    end
    else
    begin
      // a new frame flips the toggle so that the core never replays an old one
      if (!in_frame)
        frame_tog <= ~frame_tog;
      frame_clks <= in_frame ? next_clks : 14'd1;
      rx_shift   <= next_rx;
      if (clk_idx == op_clks - 14'd1)
        opcode <= next_rx[7:0];
    end
  end

  // output phase
  wire sfrc_cmd_type link_cmd = decode(opcode, shadow_proto);
  wire          is_read     = (link_cmd == CMD_RD_SR) || (link_cmd == CMD_RD_FSR) ||
                              (link_cmd == CMD_RD_NVCR) || (link_cmd == CMD_RD_VCR) ||
                              (link_cmd == CMD_RD_EVCR) || (link_cmd == CMD_FAST_READ);
  wire [13:0]   data_start  = (link_cmd == CMD_FAST_READ) ?
                              op_clks + addr_clks + {10'd0, dummy_clks} : op_clks;
  wire          drive_now   = in_frame && is_read && (frame_clks >= data_start);
  wire [7:0]    read_byte   = (link_cmd == CMD_RD_SR)   ? shadow_status :
                              (link_cmd == CMD_RD_FSR)  ? shadow_flag :
                              (link_cmd == CMD_RD_VCR)  ? shadow_vcr :
                              (link_cmd == CMD_RD_EVCR) ? shadow_evcr : ERASED_BYTE;
  // nonvolatile word goes low byte first, then zeros; the others repeat one byte
  wire [15:0]   read_word   = (link_cmd == CMD_RD_NVCR) ? (nv_done ? 16'h0000 : shadow_nvcr) :
                              {read_byte, read_byte};
  wire [7:0]    cur_byte    = out_pos[3] ? read_word[15:8] : read_word[7:0];
  wire [7:0]    out_shifted = cur_byte << out_pos[2:0];
  wire [4:0]    next_pos    = {1'b0, out_pos} + (5'd1 << lshift);
  wire [3:0]    out_bits    = (shadow_proto == PROTO_QUAD) ? out_shifted[7:4] :
                              (shadow_proto == PROTO_DUAL) ? {2'b00, out_shifted[7:6]} :
                              {2'b00, out_shifted[7], 1'b0};
  wire [3:0]    out_mask    = (shadow_proto == PROTO_QUAD) ? 4'hf :
                              (shadow_proto == PROTO_DUAL) ? 4'h3 : 4'h2;

  // data changes on the falling edge so the host samples it on the next rise
  always_ff @(negedge SCK_IN or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      DQ_OUT    <= '0;
      DQ_OE_OUT <= '0;
      out_pos   <= '0;
      nv_done   <= 1'b0;
    end
    else if (drive_now)
    begin
      DQ_OUT    <= out_bits;
      DQ_OE_OUT <= out_mask;
      out_pos   <= next_pos[3:0];
      if (next_pos[4])
        nv_done <= 1'b1;
    end
  end

  // ---------------- core domain ----------------
  logic [SYNC_W-1:0] sync_vec;
  logic              cs_prev;
  logic              tog_seen;
  logic [5:0]        sr_prot;
  logic              wel;
  logic              wip;
  logic [31:0]       busy_cnt;

  sfrc_sync
  #(
    .WIDTH       (SYNC_W),
    .RESET_VALUE (8'h80)
  )
  u_sync
  (
    .clk_in    (CLK_IN),
    .arst_n_in (ARST_N_IN),
    .async_in  ({CS_N_IN, frame_tog, PROTOCOL_IN, DUMMY_CFG_IN}),
    .sync_out  (sync_vec)
  );

  wire          cs_s       = sync_vec[7];
  wire          tog_s      = sync_vec[6];
  wire [1:0]    proto_s    = sync_vec[5:4];
  wire [3:0]    dummy_s    = sync_vec[3:0];

  // captured frame is stable here: chip select is high and the link clock idle
  // a frame too short to carry an opcode must not replay the last one
  wire          exec       = cs_s && !cs_prev && (tog_s != tog_seen) && (frame_clks >= op_clks);
  wire sfrc_cmd_type cmd   = decode(opcode, shadow_proto);
  wire [13:0]   post_bits  = (frame_clks >= op_clks) ? ((frame_clks - op_clks) << lshift) : '0;
  wire          wr_ok      = exec && wel && !wip;
  wire          do_sr      = wr_ok && (cmd == CMD_WR_SR) && (post_bits == BYTE_BITS);
  wire          do_nv      = wr_ok && (cmd == CMD_WR_NVCR) && (post_bits == NVCR_BITS);
  wire          do_vcr     = wr_ok && (cmd == CMD_WR_VCR) && (post_bits == BYTE_BITS);
  wire          do_evcr    = wr_ok && (cmd == CMD_WR_EVCR) && (post_bits == BYTE_BITS);
  wire          do_prog    = wr_ok && (cmd == CMD_PROG) && (post_bits >= ADDR_BITS + BYTE_BITS);
  wire          do_erase   = wr_ok && (cmd == CMD_ERASE_ADDR) && (post_bits == ADDR_BITS);
  wire          do_bulk    = wr_ok && (cmd == CMD_BULK) && (post_bits == '0);
  wire          do_susp    = wr_ok && (cmd == CMD_SUSPEND) && (post_bits == '0);
  wire          do_wren    = exec && (cmd == CMD_WREN) && (post_bits == '0);
  wire          do_wrdi    = exec && (cmd == CMD_WRDI) && (post_bits == '0);
  wire          start_busy = do_sr || do_nv || do_prog || do_erase || do_bulk;
  wire [31:0]   load_cnt   = do_sr    ? 32'(STATUS_WRITE_CNT) :
                             do_nv    ? 32'(NV_CONFIG_CNT) :
                             do_prog  ? 32'(PROGRAM_CNT) :
                             do_erase ? 32'(ERASE_CNT) : 32'(BULK_ERASE_CNT);
  wire [31:0]   next_busy  = start_busy ? load_cnt :
                             (busy_cnt != '0) ? busy_cnt - 32'd1 : '0;
  wire          next_wip   = (next_busy != '0);
  wire          next_wel   = do_wren ? 1'b1 :
                             (do_wrdi || start_busy || do_vcr || do_evcr || do_susp) ? 1'b0 :
                             wel;
  wire [7:0]    next_status = {sr_prot, next_wel, next_wip};

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      cs_prev  <= 1'b1;
      tog_seen <= 1'b0;
      busy_cnt <= '0;
      wip      <= 1'b0;
      wel      <= 1'b0;
    end
    else
    begin
      cs_prev  <= cs_s;
      if (exec)
        tog_seen <= tog_s;
      busy_cnt <= next_busy;
      wip      <= next_wip;
      wel      <= next_wel;
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      sr_prot     <= SR_PROT_RESET;
      NVCR_OUT    <= NVCR_RESET;
      VCR_OUT     <= VCR_RESET;
      EVCR_OUT    <= EVCR_RESET;
      STATUS_OUT  <= {SR_PROT_RESET, 2'b00};
      FLAG_STATUS_OUT <= 8'h80;
    end
    else
    begin
      if (do_sr)
        sr_prot <= rx_shift[7:2];
      // first byte received is the low byte
      if (do_nv)
        NVCR_OUT <= {rx_shift[7:0], rx_shift[15:8]};
      if (do_vcr)
        VCR_OUT <= rx_shift[7:0];
      if (do_evcr)
        EVCR_OUT <= rx_shift[7:0];
      STATUS_OUT <= next_status;
      STATUS_OUT[7:2] <= do_sr ? rx_shift[7:2] : sr_prot;
      FLAG_STATUS_OUT <= '0;
      FLAG_STATUS_OUT[FSR_RDY_BIT] <= ~next_wip;
    end
  end

  // shadows refresh only while deselected; the link reads them inside a frame
  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      shadow_status <= '0;
      shadow_flag   <= 8'h80;
      shadow_nvcr   <= NVCR_RESET;
      shadow_vcr    <= VCR_RESET;
      shadow_evcr   <= EVCR_RESET;
      shadow_proto  <= PROTO_EXT;
      shadow_dummy  <= '0;
    end
    else if (cs_s && cs_prev)
    begin
      shadow_status <= STATUS_OUT;
      shadow_flag   <= FLAG_STATUS_OUT;
      shadow_nvcr   <= NVCR_OUT;
      shadow_vcr    <= VCR_OUT;
      shadow_evcr   <= EVCR_OUT;
      shadow_proto  <= proto_s;
      shadow_dummy  <= dummy_s;
    end
  end

endmodule : sfrc_top

/* File: testbench/sfrc_top_asserts.sv */
// port assertions for the register command interpreter
`timescale 1ns/1ps
module sfrc_top_asserts
#(
  parameter int MAX_BUSY = 150
)
(
  input wire logic       CLK_IN,
  input wire logic       ARST_N_IN,
  input wire logic       CS_N_IN,
  input wire logic [3:0] DQ_OE_OUT,
  input wire logic [1:0] PROTOCOL_IN,
  input wire logic [7:0] STATUS_OUT,
  input wire logic [7:0] FLAG_STATUS_OUT,
  input wire logic [7:0] VCR_OUT,
  input wire logic [7:0] EVCR_OUT
);
  int              busy_cnt;
  wire logic [3:0] oe_exp = (PROTOCOL_IN == 2'b10) ? 4'hf : (PROTOCOL_IN == 2'b01) ? 4'h3 : 4'h2;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  // length of the current busy stretch
  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    if (!ARST_N_IN)
      busy_cnt <= 0;
    else
      busy_cnt <= FLAG_STATUS_OUT[7] ? 0 : busy_cnt + 1;
  sequence s_wip_start;
    $rose(STATUS_OUT[0]);
  endsequence
  sequence s_busy_run;
    (STATUS_OUT[0] && !FLAG_STATUS_OUT[7])[*8];
  endsequence
  AST_WIP_HOLD: assert property (s_wip_start |=> s_busy_run)
    else $error("busy ended early");
  AST_BUSY_FLAG: assert property (STATUS_OUT[0] && $past(STATUS_OUT[0]) |-> !FLAG_STATUS_OUT[7])
    else $error("ready shown while busy");
  AST_READY_WIP: assert property ($rose(FLAG_STATUS_OUT[7]) |-> ##[0:1] !STATUS_OUT[0])
    else $error("busy bit left set");
  AST_FLAG_LOW: assert property (FLAG_STATUS_OUT[6:0] == 7'h00)
    else $error("flag error bits set");
  AST_OE_IDLE: assert property (CS_N_IN |-> DQ_OE_OUT == 4'h0)
    else $error("lines driven while deselected");
  AST_OE_LINES: assert property (DQ_OE_OUT != 4'h0 |-> DQ_OE_OUT == oe_exp)
    else $error("wrong output lines");
  AST_BUSY_BOUND: assert property (busy_cnt <= MAX_BUSY + 2)
    else $error("busy too long");
  AST_CFG_FRAME: assert property ((!CS_N_IN)[*7] |-> $stable(VCR_OUT) && $stable(EVCR_OUT))
    else $error("config changed mid frame");
  AST_WEL_AT_END: assert property ($rose(STATUS_OUT[1]) |-> CS_N_IN && $past(CS_N_IN, 3))
    else $error("latch set inside frame");
  AST_PROT_BUSY: assert property (STATUS_OUT[0] && $past(STATUS_OUT[0]) |-> $stable(STATUS_OUT[7:2]))
    else $error("protection changed while busy");
endmodule : sfrc_top_asserts

bind sfrc_top sfrc_top_asserts #(.MAX_BUSY(STATUS_WRITE_CNT)) u_sfrc_top_asserts (.CLK_IN(CLK_IN),
  .ARST_N_IN(ARST_N_IN), .CS_N_IN(CS_N_IN), .DQ_OE_OUT(DQ_OE_OUT), .PROTOCOL_IN(PROTOCOL_IN),
  .STATUS_OUT(STATUS_OUT), .FLAG_STATUS_OUT(FLAG_STATUS_OUT), .VCR_OUT(VCR_OUT), .EVCR_OUT(EVCR_OUT));

/* File: testbench/sfrc_host.sv */
// host link model: opcode and data out, idle clocks, read-back
`timescale 1ns/1ps
module sfrc_host
(
  // link
  output logic            sck_out,
  output logic            cs_n_out,
  output logic      [3:0] dq_out,
  input  wire logic [3:0] dq_in,
  // active protocol
  input  wire logic [1:0] proto_in
);
  initial
  begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    dq_out   = 4'h5;
  end
  task automatic pulse();
    #6 sck_out = 1'b1;
    #6 sck_out = 1'b0;
  endtask : pulse
  // nt bits msb first, nd idle clocks, nr bits back
  task automatic xfer(input logic [47:0] tx, input int nt, input int nd, input int nr,
                      output logic [31:0] rx);
    int w;
    w = (proto_in == 2'b10) ? 4 : (proto_in == 2'b01) ? 2 : 1;
    rx = '0;
    cs_n_out = 1'b0;
    #250;
    for (int i = nt; i > 0; i -= w)
    begin
      dq_out = 4'(tx >> (i - w));
      pulse();
    end
    for (int i = 0; i < nd; i++)
    begin
      dq_out = ~dq_out;
      pulse();
    end
    // released lines toggle so a stale level never passes
    for (int i = 0; i < nr; i += w)
    begin
      dq_out = ~dq_out;
      #6 sck_out = 1'b1;
      rx = (rx << w) | ((w == 1) ? 32'(dq_in[1]) : 32'(dq_in & 4'((1 << w) - 1)));
      #6 sck_out = 1'b0;
    end
    #6;
    cs_n_out = 1'b1;
    #300;
  endtask : xfer
endmodule : sfrc_host

/* File: testbench/sfrc_tb_top.sv */
// self-checking bench: host model, reference model, port compares
`timescale 1ns/1ps
module sfrc_tb_top
  import sfrc_pkg::*;
();
  logic        clk;
  logic        rst_n;
  logic        sck;
  logic        cs_n;
  logic [1:0]  proto;
  logic [3:0]  dcfg, hdq, dqo, oe, dq;
  logic [7:0]  st, fl, vcr, evcr;
  logic [15:0] nv;
  logic [31:0] rx, d;
  logic [15:0] tbl[$];
  int          num_errors = 0;
  int          n_checks = 0;
  int          seed = 32'h3eb5;
  int          m_prot = 0;
  int          w;
  assign dq = (oe & dqo) | (~oe & hdq);
  sfrc_top #(.STATUS_WRITE_CNT(150), .NV_CONFIG_CNT(120), .PROGRAM_CNT(20), .ERASE_CNT(25),
    .BULK_ERASE_CNT(40)) u_sfrc_top (.CLK_IN(clk), .ARST_N_IN(rst_n), .SCK_IN(sck), .CS_N_IN(cs_n),
    .DQ_IN(dq), .DQ_OUT(dqo), .DQ_OE_OUT(oe), .PROTOCOL_IN(proto), .DUMMY_CFG_IN(dcfg),
    .STATUS_OUT(st), .FLAG_STATUS_OUT(fl), .NVCR_OUT(nv), .VCR_OUT(vcr), .EVCR_OUT(evcr));
  sfrc_host u_sfrc_host (.sck_out(sck), .cs_n_out(cs_n), .dq_out(hdq), .dq_in(dq), .proto_in(proto));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  function automatic logic [7:0] m_st(input logic wel, input logic wip);
    return {6'(m_prot), wel, wip};
  endfunction : m_st
  task automatic cmd(input logic [7:0] op, input logic [31:0] dat, input int nb);
    u_sfrc_host.xfer((48'(op) << nb) | (48'(dat) & ((48'h1 << nb) - 48'h1)), 8 + nb, 0, 0, rx);
  endtask : cmd
  task automatic rd(input logic [7:0] op, input int nr);
    u_sfrc_host.xfer(48'(op), 8, 0, nr, rx);
  endtask : rd
  task automatic wait_ready();
    int n;
    n = 0;
    while (fl[7] !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    check(fl[7], 1'b1);
    repeat (2) @(posedge clk);
  endtask : wait_ready
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // whole run is near 130 us
  initial
  begin
    #1ms;
    num_errors++;
    give_verdict();
  end
  initial
  begin
    rst_n = 1'b0;
    proto = 2'b00;
    dcfg  = 4'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    check({st, fl, vcr, evcr}, 32'h0080fbdf);
    check(nv, 16'hffff);
    $display("reset test done");
    for (int p = 0; p < 3; p++)
    begin
      @(posedge clk);
      proto <= 2'(p);
      repeat (8) @(posedge clk);
      w = 1 << p;
      rd(OP_RD_SR, 16);
      check(rx, {m_st(1'b0, 1'b0), m_st(1'b0, 1'b0)});
      rd(OP_RD_FSR, 16);
      check(rx, 32'h8080);
      d = $random(seed);
      cmd(OP_WREN, 0, 0);
      check(st[1], 1'b1);
      cmd(OP_WR_SR, d, 8);
      m_prot = d[7:2];
      check({st, fl}, {m_st(1'b0, 1'b1), 8'h00});
      rd(OP_RD_SR, 8);
      check(rx, m_st(1'b0, 1'b1));
      rd(OP_RD_FSR, 8);
      check(rx, 32'h00);
      wait_ready();
      check(st, m_st(1'b0, 1'b0));
      cmd(OP_WREN, 0, 0);
      cmd(OP_WR_SR, ~d, 8 + w);
      check({st, fl}, {m_st(1'b1, 1'b0), 8'h80});
      cmd(OP_WRDI, 0, 0);
      check(st, m_st(1'b0, 1'b0));
      cmd(OP_WREN, 0, 0);
      cmd(OP_WR_VCR, d, 8);
      rd(OP_RD_VCR, 16);
      check({vcr, rx[15:0]}, {d[7:0], d[7:0], d[7:0]});
      cmd(OP_WREN, 0, 0);
      cmd(OP_WR_EVCR, ~d, 8);
      rd(OP_RD_EVCR, 24);
      check({evcr, rx[23:0]}, {4{~d[7:0]}});
      cmd(OP_WREN, 0, 0);
      cmd(OP_WR_NVCR, {d[7:0], d[15:8]}, 16);
      check(st[0], 1'b1);
      wait_ready();
      check({st, nv}, {m_st(1'b0, 1'b0), d[15:0]});
      rd(OP_RD_NVCR, 24);
      check(rx, {d[7:0], d[15:8], 8'h00});
      case (p)
        0: tbl = '{16'h02a0, 16'h2098, 16'hd898, 16'hc780, 16'h42a0};
        1: tbl = '{16'ha2a0, 16'hd2a0, 16'h3220};
        default: tbl = '{16'h32a0, 16'h12a0, 16'ha220, 16'hd220};
      endcase
      // entry: opcode, accepted flag, bits after opcode
      foreach (tbl[i])
      begin
        cmd(OP_WREN, 0, 0);
        cmd(tbl[i][15:8], $random(seed), int'(tbl[i][6:0]));
        check({fl[7], st[1] | tbl[i][7]}, {~tbl[i][7], 1'b1});
        wait_ready();
        cmd(OP_WRDI, 0, 0);
      end
      foreach (tbl[i])
      begin
        cmd(OP_WREN, 0, 0);
        cmd((i % 2 == 0) ? OP_SUSPEND : OP_RESUME, 0, 0);
        check(st, m_st(1'b0, 1'b0));
      end
      @(posedge clk);
      dcfg <= 4'(($random(seed) & 7) + 1);
      repeat (8) @(posedge clk);
      u_sfrc_host.xfer(48'({OP_FAST_READ, d[23:0]}), 32, int'(dcfg), 8, rx);
      check(rx, 32'hff);
      @(posedge clk);
      dcfg <= 4'h0;
      repeat (8) @(posedge clk);
      u_sfrc_host.xfer(48'({OP_OTP_READ, d[23:0]}), 32, (p == 2) ? 10 : 8, 8, rx);
      check(rx, 32'hff);
      $display("protocol %0d test done", p);
    end
    give_verdict();
  end
endmodule : sfrc_tb_top
